// ---- logic/mccs_clock_scheme.sv ----
`timescale 1ns/10ps
// How it works
// - two double-rate system clocks supplied, the second shifted 180 degrees
// - controller halves the double-rate clock into the single-rate memory clock
// - physical layer emits one data bit per double-rate clock period
// - buffer makes zero-phase and ninety-degree enables, divide 2, locked to zero phase
// - only the first two PLL outputs feed the system clock buffer
// - calibration clock comes from the same PLL, in phase with zero-degree domain
// - calibration clock at least 50 MHz, typically about 100 MHz
// - each of six ports has command, write and read clock inputs
// - user pushes write data on write clock, pops read data on read clock
// - port clocks are crossed safely into the system clock domain
// - two controllers on one side share one clock pair and data rate
// - system clocks come only from the PLL through the I/O clock network
// - I/O clock network allows data rates up to 800 Mb/s
module mccs_clock_scheme
	import mccs_pkg::*;
#(
	parameter int PORTS = PORT_COUNT
) (
	// clock and reset; clk is the zero-phase double-rate clock
	input wire logic clk,
	input wire logic rst_b,
	// PLL status, asynchronous
	input wire logic pll_locked,
	// single-rate data pair to serialise
	input wire logic [1:0] ser_data_in,
	// user port clocks, asynchronous
	input wire logic [PORTS-1:0] port_command_clock,
	input wire logic [PORTS-1:0] port_write_clock,
	input wire logic [PORTS-1:0] port_read_clock,
	// derived clocks and strobes
	output logic clocks_ready,
	output logic fast_clock_antiphase,
	output logic mem_clock,
	output logic mem_clock_second,
	output logic strobe_ce_zero,
	output logic strobe_ce_ninety,
	output logic cal_tick,
	output logic ddr_bit,
	// port clock edges seen in the system domain
	output logic [PORTS-1:0] port_command_edge,
	output logic [PORTS-1:0] port_write_edge,
	output logic [PORTS-1:0] port_read_edge
);

	// ****************************************************
	// synchronisers
	// ****************************************************
	logic lock_s1_reg, lock_s2_reg;
	logic [PORTS-1:0] cmd_s1_reg, cmd_s2_reg, cmd_s3_reg;
	logic [PORTS-1:0] wr_s1_reg, wr_s2_reg, wr_s3_reg;
	logic [PORTS-1:0] rd_s1_reg, rd_s2_reg, rd_s3_reg;

	// lock accepted only from the PLL
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lock_s1_reg <= 1'b0;
			lock_s2_reg <= 1'b0;
		end else begin
			lock_s1_reg <= pll_locked;
			lock_s2_reg <= lock_s1_reg;
		end
	end

	// two-flop crossing of each user clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_s1_reg <= '0;
			cmd_s2_reg <= '0;
			cmd_s3_reg <= '0;
			wr_s1_reg <= '0;
			wr_s2_reg <= '0;
			wr_s3_reg <= '0;
			rd_s1_reg <= '0;
			rd_s2_reg <= '0;
			rd_s3_reg <= '0;
		end else begin
			cmd_s1_reg <= port_command_clock;
			cmd_s2_reg <= cmd_s1_reg;
			cmd_s3_reg <= cmd_s2_reg;
			wr_s1_reg <= port_write_clock;
			wr_s2_reg <= wr_s1_reg;
			wr_s3_reg <= wr_s2_reg;
			rd_s1_reg <= port_read_clock;
			rd_s2_reg <= rd_s1_reg;
			rd_s3_reg <= rd_s2_reg;
		end
	end

	// separate rising-edge detect per port clock
	wire [PORTS-1:0] cmd_edge_next = cmd_s2_reg & ~cmd_s3_reg;
	// write push and read pop clocks tracked apart
	wire [PORTS-1:0] wr_edge_next = wr_s2_reg & ~wr_s3_reg;
	wire [PORTS-1:0] rd_edge_next = rd_s2_reg & ~rd_s3_reg;

	// ****************************************************
	// lock and alignment
	// ****************************************************
	mccs_state_e state_reg, state_next;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			MCCS_WAIT_LOCK: begin
				if (lock_s2_reg)
					state_next = MCCS_ALIGN;
			end
			MCCS_ALIGN: begin
				state_next = lock_s2_reg ? MCCS_RUN : MCCS_WAIT_LOCK;
			end
			MCCS_RUN: begin
				if (!lock_s2_reg)
					state_next = MCCS_WAIT_LOCK;
			end
			default: begin
				state_next = MCCS_WAIT_LOCK;
			end
		endcase
	end

	wire run_next = (state_next == MCCS_RUN);

	// ****************************************************
	// divider, strobes, serialiser
	// ****************************************************
	logic phase_reg;
	logic [1:0] word_reg;
	logic [7:0] cal_count_reg;

	// halve the fast clock; phase zero restarts on a zero-degree edge
	wire phase_next = (run_next && state_reg == MCCS_RUN) ? ~phase_reg : RST_PHASE;
	wire slot_zero = run_next && !phase_next;
	// first bit on phase zero, second on phase one
	wire ddr_bit_next = !run_next ? RST_DDR_BIT : (slot_zero ? ser_data_in[0] : word_reg[1]);
	// calibration tick counted from the zero-phase domain
	wire cal_wrap = (cal_count_reg == 8'(CAL_DIV - 1));
	wire [7:0] cal_count_next = (!run_next || cal_wrap) ? RST_CAL_COUNT : cal_count_reg + 8'h01;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= MCCS_WAIT_LOCK;
			phase_reg <= RST_PHASE;
			word_reg <= RST_WORD;
			cal_count_reg <= RST_CAL_COUNT;
		end else begin
			state_reg <= state_next;
			phase_reg <= phase_next;
			word_reg <= slot_zero ? ser_data_in : word_reg;
			cal_count_reg <= cal_count_next;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			clocks_ready <= 1'b0;
			fast_clock_antiphase <= RST_PHASE;
			mem_clock <= RST_MEM_CLOCK;
			mem_clock_second <= RST_MEM_CLOCK;
			strobe_ce_zero <= RST_STROBE;
			strobe_ce_ninety <= RST_STROBE;
			cal_tick <= RST_STROBE;
			ddr_bit <= RST_DDR_BIT;
			port_command_edge <= '0;
			port_write_edge <= '0;
			port_read_edge <= '0;
		end else begin
			clocks_ready <= run_next;
			// antiphase partner of the fast clock, level shown low with clk high
			fast_clock_antiphase <= 1'b0;
			mem_clock <= slot_zero;
			// second controller on the same side shares the divider
			mem_clock_second <= slot_zero;
			// both enables from one divide-by-2 on the zero-phase reference
			strobe_ce_zero <= slot_zero;
			strobe_ce_ninety <= slot_zero;
			cal_tick <= run_next && (cal_count_next == RST_CAL_COUNT);
			ddr_bit <= ddr_bit_next;
			port_command_edge <= cmd_edge_next;
			port_write_edge <= wr_edge_next;
			port_read_edge <= rd_edge_next;
		end
	end

	// ****************************************************
	// assertions
	// ****************************************************
	property p_mem_toggle;
		@(posedge clk) disable iff (!rst_b)
		clocks_ready && $past(clocks_ready) |-> mem_clock != $past(mem_clock);
	endproperty
	a_mem_toggle: assert property (p_mem_toggle) else $error("memory clock not half rate");

	property p_ce_period;
		@(posedge clk) disable iff (!rst_b)
		strobe_ce_zero ##1 clocks_ready |-> !strobe_ce_zero ##1 (strobe_ce_zero || !clocks_ready);
	endproperty
	a_ce_period: assert property (p_ce_period) else $error("enable not every second cycle");

	property p_ce_pair;
		@(posedge clk) disable iff (!rst_b)
		strobe_ce_ninety == strobe_ce_zero;
	endproperty
	a_ce_pair: assert property (p_ce_pair) else $error("enables out of step");

	property p_align;
		@(posedge clk) disable iff (!rst_b)
		$rose(clocks_ready) |-> strobe_ce_zero && mem_clock;
	endproperty
	a_align: assert property (p_align) else $error("divider not aligned at start");

	property p_ddr_first;
		@(posedge clk) disable iff (!rst_b)
		strobe_ce_zero |-> ddr_bit == $past(ser_data_in[0]);
	endproperty
	a_ddr_first: assert property (p_ddr_first) else $error("first bit wrong");

	property p_ddr_second;
		@(posedge clk) disable iff (!rst_b)
		strobe_ce_zero ##1 clocks_ready |-> ddr_bit == $past(ser_data_in[1], 2);
	endproperty
	a_ddr_second: assert property (p_ddr_second) else $error("second bit wrong");

	property p_share;
		@(posedge clk) disable iff (!rst_b)
		mem_clock_second == mem_clock;
	endproperty
	a_share: assert property (p_share) else $error("shared clocks differ");

	localparam logic CAL_MHZ_OK = (CLK_MHZ / CAL_DIV) >= CAL_MIN_MHZ;
	property p_cal;
		@(posedge clk) disable iff (!rst_b)
		clocks_ready |-> cal_count_reg < 8'(CAL_DIV) && (CAL_MHZ_OK == 1'b1);
	endproperty
	a_cal: assert property (p_cal) else $error("calibration rate out of range");

	property p_ready_lock;
		@(posedge clk) disable iff (!rst_b)
		clocks_ready |-> $past(lock_s2_reg) && (LANE_RATE_MBPS <= MAX_RATE_MBPS);
	endproperty
	a_ready_lock: assert property (p_ready_lock) else $error("running without lock");

	property p_port_pulse;
		@(posedge clk) disable iff (!rst_b)
		(port_command_edge | port_write_edge | port_read_edge) != '0 |=>
			((port_command_edge & $past(port_command_edge)) | (port_write_edge & $past(port_write_edge))
			| (port_read_edge & $past(port_read_edge))) == '0;
	endproperty
	a_port_pulse: assert property (p_port_pulse) else $error("port edge longer than a cycle");

endmodule : mccs_clock_scheme

// ---- logic/mccs_pkg.sv ----
package mccs_pkg;

	// ****************************************************
	// clock relations
	// ****************************************************
	localparam int FAST_DIVIDE = 2;
	localparam int ANTIPHASE_DEG = 180;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLK_MHZ = 1000 / CLK_PERIOD_NS;
	localparam int CAL_MIN_MHZ = 50;
	localparam int CAL_TYP_MHZ = 100;
	localparam int CAL_PERIOD_NS = 1000 / CAL_TYP_MHZ;
	// cycles per calibration tick, typical period rounds down, at least one
	localparam int CAL_DIV_RAW = CAL_PERIOD_NS / CLK_PERIOD_NS;
	localparam int CAL_DIV = (CAL_DIV_RAW < 1) ? 1 : CAL_DIV_RAW;
	localparam int MAX_RATE_MBPS = 800;
	localparam int LANE_RATE_MBPS = CLK_MHZ;
	localparam int PORT_COUNT = 6;

	// ****************************************************
	// reset values
	// ****************************************************
	localparam logic RST_PHASE = 1'b0;
	localparam logic RST_MEM_CLOCK = 1'b0;
	localparam logic RST_STROBE = 1'b0;
	localparam logic RST_DDR_BIT = 1'b0;
	localparam logic [1:0] RST_WORD = 2'h0;
	localparam logic [7:0] RST_CAL_COUNT = 8'h00;

	typedef enum logic [1:0] {
		MCCS_WAIT_LOCK = 2'b00,
		MCCS_ALIGN = 2'b01,
		MCCS_RUN = 2'b11
	} mccs_state_e;

endpackage : mccs_pkg

// ---- tb/mccs_user_model.sv ----
`timescale 1ns/10ps
module mccs_user_model (
	// request from the bench
	input wire logic clk,
	input wire logic req,
	input wire logic [2:0] req_port,
	input wire logic [2:0] req_kinds,
	// user port clocks
	output logic [5:0] cmd_ck,
	output logic [5:0] wr_ck,
	output logic [5:0] rd_ck
);
	int cnt = 0;
	logic [2:0] kinds = 3'h0;
	logic [5:0] sel = 6'h00;
	always @(posedge clk) begin
		if (req) begin
			sel <= #1 6'h01 << req_port;
			kinds <= #1 req_kinds;
			cnt <= #1 6;
		end else if (cnt > 0) begin
			cnt <= #1 cnt - 1;
		end
	end
	assign cmd_ck = (cnt > 3 && kinds[0]) ? sel : 6'h00;
	assign wr_ck = (cnt > 3 && kinds[1]) ? sel : 6'h00;
	assign rd_ck = (cnt > 3 && kinds[2]) ? sel : 6'h00;
endmodule : mccs_user_model

// ---- tb/mccs_clock_scheme_tb_top.sv ----
`timescale 1ns/10ps
module mccs_clock_scheme_tb_top;
	import mccs_pkg::*;
	logic clk = 0, rst_b = 0, pll_locked = 0, req = 0;
	logic [1:0] ser_data_in = 2'h0;
	logic [2:0] req_port = 3'h0, req_kinds = 3'h0;
	logic [5:0] cmd_ck, wr_ck, rd_ck, cmd_e, wr_e, rd_e, b;
	logic clocks_ready, fast_clock_antiphase, mem_clock, mem_clock_second;
	logic strobe_ce_zero, strobe_ce_ninety, cal_tick, ddr_bit;
	int n_fail = 0, checks_done = 0, cyc = 0;
	typedef struct {logic [17:0] vec; int at;} mccs_note_s;
	mccs_note_s notes[$];
	mccs_note_s nt, nw;
	mccs_clock_scheme #(.PORTS(6)) dut (.clk(clk), .rst_b(rst_b), .pll_locked(pll_locked),
		.ser_data_in(ser_data_in), .port_command_clock(cmd_ck), .port_write_clock(wr_ck),
		.port_read_clock(rd_ck), .clocks_ready(clocks_ready), .fast_clock_antiphase(fast_clock_antiphase),
		.mem_clock(mem_clock), .mem_clock_second(mem_clock_second), .strobe_ce_zero(strobe_ce_zero),
		.strobe_ce_ninety(strobe_ce_ninety), .cal_tick(cal_tick), .ddr_bit(ddr_bit),
		.port_command_edge(cmd_e), .port_write_edge(wr_e), .port_read_edge(rd_e));
	mccs_user_model user (.clk(clk), .req(req), .req_port(req_port), .req_kinds(req_kinds),
		.cmd_ck(cmd_ck), .wr_ck(wr_ck), .rd_ck(rd_ck));
	initial forever #5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	// ****
	// checking
	// ****
	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task test_done;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : test_done
	task wait_ready(input logic lvl, input int lo, input int hi);
		int k;
		k = 0;
		while (clocks_ready !== lvl && k <= hi) begin
			@(posedge clk);
			#1;
			k++;
		end
		check("ready delay", 32'(k >= lo && k <= hi), 32'h1);
		if (k > hi) test_done();
	endtask : wait_ready
	task quiet;
		check("outputs idle", {clocks_ready, mem_clock, strobe_ce_zero, cal_tick, cmd_e, wr_e, rd_e}, 0);
	endtask : quiet
	// port edges are matched against the oldest note
	always @(posedge clk) begin
		#1;
		if (rst_b && |{rd_e, wr_e, cmd_e}) begin
			if (notes.size() == 0) begin
				check("spare port edge", 1, 0);
			end else begin
				nt = notes.pop_front();
				check("port edges", {rd_e, wr_e, cmd_e}, nt.vec);
				check("port edge delay", 32'(cyc >= nt.at && cyc <= nt.at + 1), 32'h1);
			end
		end
	end
	initial begin
		void'($urandom(44));
		repeat (10) @(posedge clk);
		#1;
		quiet();
		rst_b = 1;
		pll_locked = 1;
		wait_ready(1'b1, 4, 5);
		for (int i = 0; i < 8; i++) begin
			check("mem clock", mem_clock, 32'(i % 2 == 0));
			check("second clock", mem_clock_second, 32'(i % 2 == 0));
			check("ce zero", strobe_ce_zero, 32'(i % 2 == 0));
			check("ce ninety", strobe_ce_ninety, 32'(i % 2 == 0));
			check("antiphase", fast_clock_antiphase, 0);
			check("cal tick", cal_tick, 1);
			@(posedge clk);
			#1;
		end
		for (int r = 0; r < 4; r++) begin
			ser_data_in = 2'($urandom);
			repeat (4) @(posedge clk);
			for (int j = 0; j < 4; j++) begin
				@(posedge clk);
				#1;
				check("ddr bit", ddr_bit, (j % 2 == 1) ? ser_data_in[0] : ser_data_in[1]);
			end
		end
		for (int i = 0; i < 12; i++) begin
			@(posedge clk);
			#1;
			req_port = (i < 6) ? 3'(i) : 3'($urandom % 6);
			req_kinds = (i < 6) ? 3'h7 : 3'($urandom % 7 + 1);
			b = 6'h01 << req_port;
			nw.vec = {req_kinds[2] ? b : 6'h00, req_kinds[1] ? b : 6'h00, req_kinds[0] ? b : 6'h00};
			nw.at = cyc + 4;
			notes.push_back(nw);
			req = 1;
			@(posedge clk);
			#1;
			req = 0;
			repeat (7) @(posedge clk);
		end
		repeat (6) @(posedge clk);
		#1;
		check("notes left", notes.size(), 0);
		pll_locked = 0;
		wait_ready(1'b0, 3, 5);
		@(posedge clk);
		#1;
		quiet();
		pll_locked = 1;
		wait_ready(1'b1, 4, 5);
		rst_b = 0;
		#1;
		quiet();
		@(posedge clk);
		#1;
		rst_b = 1;
		wait_ready(1'b1, 4, 5);
		test_done();
	end
endmodule : mccs_clock_scheme_tb_top
